/* sim/kbd_model.sv */
/*
 * Far side of the bank: a 2x2 key matrix on pins 0..3 plus free drive.
 * Assumes rows on pins 0..1 with pull-ups, columns on pins 2..3.
 */
module kbd_model
	import gpio_bank_pkg::*;
(
	input  wire logic [NPIN-1:0] pad_out,
	input  wire logic [NPIN-1:0] pad_oe,
	input  wire logic [NPIN-1:0] ext_in,
	input  wire logic [3:0]      press,
	output logic      [NPIN-1:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NPIN-1:0] lvl;
	always_comb
	begin
		// an enabled driver wins over the outside level
		lvl = (pad_oe & pad_out) | (~pad_oe & ext_in);
		pad_in = lvl;
		for (int r = 0; r < 2; r++)
		begin
			pad_in[r] = 1'b1; // pull-up lives outside the bank
			for (int c = 0; c < 2; c++)
				// a released column floats and cannot pull its row down
				if (press[r*2+c] && pad_oe[2+c] && !pad_out[2+c])
					pad_in[r] = 1'b0;
		end
	end
endmodule : kbd_model

/* sim/tb.sv */
/*
 * Self-checking bench: APB master tasks and one task per scenario.
 * Assumes the key matrix model on pins 0..3 and no debounce at start.
 */
module tb
	import gpio_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic            sys_clk = 1'b0;
	logic            dbclk   = 1'b0;
	logic            rstn    = 1'b0;
	logic            psel    = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite  = 1'b0;
	logic [AW-1:0]   paddr   = '0;
	logic [31:0]     pwdata  = '0;
	logic            idle_req = 1'b0;
	logic [NPIN-1:0] ext_in  = '0;
	logic [3:0]      press   = 4'h0;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic [NPIN-1:0] pad_in;
	logic [NPIN-1:0] pad_out;
	logic [NPIN-1:0] pad_oe;
	logic            irq_first;
	logic            irq_second;
	logic            idle_ack;
	logic            wake_req;
	logic [31:0]     q;
	logic            e;
	int              err_count = 0;
	int              check_count = 0;

	gpio_bank i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_in), .PAD_OUT(pad_out),
		.PAD_OE(pad_oe), .DBCLK(dbclk), .IRQ_FIRST(irq_first), .IRQ_SECOND(irq_second),
		.IDLE_REQ(idle_req), .IDLE_ACK(idle_ack), .WAKE_REQ(wake_req));
	kbd_model i_far (.pad_out(pad_out), .pad_oe(pad_oe), .ext_in(ext_in), .press(press),
		.pad_in(pad_in));

	initial
		forever #50 sys_clk = ~sys_clk;
	// slow clock phase unrelated to the bus clock
	initial
		forever #15259 dbclk = ~dbclk;

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_count++;
			test_done();
		end
	endtask : apb

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask : rdc

	function automatic logic [31:0] sig(input int k);
		case (k)
			0: sig = {31'h0, irq_first};
			1: sig = {31'h0, irq_second};
			2: sig = {31'h0, idle_ack};
			default: sig = {31'h0, wake_req};
		endcase
	endfunction : sig

	task automatic wait_sig(input int k, input logic [31:0] v);
		int n;
		n = 0;
		do
		begin
			@(negedge sys_clk);
			n++;
		end
		while (sig(k) !== v && n < 50);
		chk(sig(k), v);
		if (sig(k) !== v)
			test_done();
	endtask : wait_sig

	// pin change plus time for the two-flop synchroniser
	task automatic pin(input int i, input logic v);
		@(posedge sys_clk);
		ext_in[i] <= v;
		repeat (6) @(posedge sys_clk);
	endtask : pin

	task automatic t_reset();
		@(negedge sys_clk);
		chk(pad_oe, 32'h0000_0000);
		rdc(OFF_SYS, 32'h0000_0010);
		rdc(OFF_STAT, 32'h0000_0001);
	endtask : t_reset

	task automatic t_output();
		wr(OFF_OE, 32'h0000_F0FC);
		wr(OFF_OUT, 32'hA5A5_0000);
		wr(OFF_OUT + OFF_SET_INC, 32'h0000_00F3);
		wr(OFF_OUT + OFF_CLR_INC, 32'hA000_0000);
		@(negedge sys_clk);
		chk(pad_oe, 32'h0000_F0FC);
		chk(pad_out, 32'h05A5_00F3);
		rdc(OFF_OUT + OFF_CLR_INC, 32'h05A5_00F3);
	endtask : t_output

	task automatic t_input();
		pin(31, 1'b0);
		ext_in <= 32'h3C3C_5A5A;
		repeat (6) @(posedge sys_clk);
		rdc(OFF_DIN, 32'h0000_00F0 | 32'h3C3C_0A02 | 32'h0000_0003);
		ext_in <= 32'h0000_0000;
		wr(OFF_OE, 32'h0000_000C);
	endtask : t_input

	task automatic t_detect();
		logic [AW-1:0] off [4] = '{OFF_RISE, OFF_FALL, OFF_LOW, OFF_HIGH};
		logic          pre [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		wr(OFF_IEN1 + OFF_SET_INC, 32'h0000_0100);
		for (int m = 0; m < 4; m++)
		begin
			pin(8, pre[m]);
			wr(off[m], 32'h0000_0100);
			wr(OFF_ST1, 32'hFFFF_FFFF);
			rdc(OFF_ST1, 32'h0000_0000);
			pin(8, ~pre[m]);
			wait_sig(0, 32'h1);
			chk(sig(1), 32'h0);
			rdc(OFF_ST1, 32'h0000_0100);
			wr(off[m], 32'h0000_0000);
			wr(OFF_ST1, 32'h0000_0100);
			wait_sig(0, 32'h0);
		end
		wr(OFF_IEN1 + OFF_CLR_INC, 32'h0000_0001);
		rdc(OFF_IEN1, 32'h0000_0100);
	endtask : t_detect

	task automatic t_keys();
		wr(OFF_LOW, 32'h0000_0003);
		wr(OFF_ST2, 32'hFFFF_FFFF);
		wr(OFF_IEN2 + OFF_SET_INC, 32'h0000_0003);
		@(posedge sys_clk);
		press <= 4'h4;
		wait_sig(1, 32'h1);
		rdc(OFF_ST2, 32'h0000_0002);
		wr(OFF_IEN2 + OFF_CLR_INC, 32'h0000_0003);
		// one column low at a time, rows read back
		for (int c = 0; c < 2; c++)
		begin
			wr(OFF_OUT, 32'h0000_000C & ~(32'h0000_0004 << c));
			repeat (6) @(posedge sys_clk);
			apb(1'b0, OFF_DIN, 32'h0000_0000);
			chk({30'h0, q[1:0]}, (c == 0) ? 32'h1 : 32'h3);
		end
		@(posedge sys_clk);
		press <= 4'h0;
		wr(OFF_OUT, 32'h0000_0000);
		repeat (6) @(posedge sys_clk);
		wr(OFF_ST2, 32'hFFFF_FFFF);
		wr(OFF_IEN2 + OFF_SET_INC, 32'h0000_0003);
		rdc(OFF_IEN2, 32'h0000_0003);
		wait_sig(1, 32'h0);
	endtask : t_keys

	task automatic t_disable();
		wr(OFF_CTRL, 32'h0000_0001);
		wr(OFF_RISE, 32'h0000_0100);
		pin(8, 1'b0);
		pin(8, 1'b1);
		rdc(OFF_ST1, 32'h0000_0000);
		chk(sig(0), 32'h0);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_ST1, 32'hFFFF_FFFF);
	endtask : t_disable

	task automatic t_idle();
		wr(OFF_WEN + OFF_SET_INC, 32'h0000_0200);
		wr(OFF_RISE, 32'h0000_0300);
		pin(8, 1'b0);
		pin(8, 1'b1);
		wait_sig(0, 32'h1);
		@(posedge sys_clk);
		idle_req <= 1'b1;
		// pending status must hold off the acknowledge
		repeat (10) @(negedge sys_clk);
		chk(sig(2), 32'h0);
		wr(OFF_ST1, 32'hFFFF_FFFF);
		wait_sig(2, 32'h1);
		pin(9, 1'b1);
		wait_sig(3, 32'h1);
		chk(sig(0), 32'h0);
		@(posedge sys_clk);
		idle_req <= 1'b0;
		wait_sig(3, 32'h0);
		chk(sig(2), 32'h0);
		rdc(OFF_ST1, 32'h0000_0000);
	endtask : t_idle

	// never-acknowledge mode, then forced mode with status still pending
	task automatic t_modes();
		wr(OFF_SYS, 32'h0000_0008);
		@(posedge sys_clk);
		idle_req <= 1'b1;
		repeat (10) @(negedge sys_clk);
		chk(sig(2), 32'h0);
		@(posedge sys_clk);
		idle_req <= 1'b0;
		pin(8, 1'b0);
		pin(8, 1'b1);
		wr(OFF_SYS, 32'h0000_0000);
		@(posedge sys_clk);
		idle_req <= 1'b1;
		wait_sig(2, 32'h1);
		rdc(OFF_ST1, 32'h0000_0100);
		@(posedge sys_clk);
		idle_req <= 1'b0;
		wait_sig(2, 32'h0);
		wr(OFF_ST1, 32'hFFFF_FFFF);
		wr(OFF_SYS, 32'h0000_0010);
	endtask : t_modes

	task automatic t_debounce();
		int n;
		wr(OFF_DBT, 32'h0000_0001);
		wr(OFF_DBEN, 32'h0000_0400);
		repeat (700) @(posedge sys_clk);
		pin(10, 1'b1);
		for (n = 0; n < 60; n++)
		begin
			repeat (100) @(posedge sys_clk);
			apb(1'b0, OFF_DIN, 32'h0000_0000);
			if (q[10] === 1'b1)
				break;
		end
		chk({31'h0, q[10]}, 32'h1);
		chk({31'h0, n >= 2}, 32'h1);
	endtask : t_debounce

	task automatic t_soft();
		wr(OFF_OE, 32'hFFFF_FFFF);
		wr(OFF_SYS, 32'h0000_0002);
		rdc(OFF_SYS, 32'h0000_0010);
		rdc(OFF_STAT, 32'h0000_0001);
		rdc(OFF_IEN1, 32'h0000_0000);
		chk(pad_oe, 32'h0000_0000);
	endtask : t_soft

	task automatic t_unmapped();
		apb(1'b0, 8'h64, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk({31'h0, e}, 32'h1);
	endtask : t_unmapped

	initial
	begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_output();
		t_input();
		t_detect();
		t_keys();
		t_disable();
		t_idle();
		t_modes();
		t_debounce();
		t_soft();
		t_unmapped();
		test_done();
	end
endmodule : tb

/* src/debounce_cell.sv */
/*
 * Per-pin debounce filter advanced by ticks of the slow debounce clock.
 * Assumes raw inputs already synchronised and tick a one-cycle pulse.
 */
module debounce_cell
	import gpio_bank_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            tick,
	input  wire logic [NPIN-1:0] raw,
	input  wire logic [NPIN-1:0] en,
	input  wire logic [DBTW-1:0] dtime,
	output logic      [NPIN-1:0] filt
);
	logic [NPIN-1:0] stable_r;
	logic [NPIN-1:0] stable_nxt;
	logic [DBTW-1:0] cnt_r   [NPIN];
	logic [DBTW-1:0] cnt_nxt [NPIN];
	logic [DBTW-1:0] time_r;
	logic [DBTW-1:0] time_nxt;

	always_comb
	begin
		// time setting crosses over only on a tick, one value for all pins
		time_nxt = tick ? dtime : time_r;
		for (int i = 0; i < NPIN; i++)
		begin
			stable_nxt[i] = stable_r[i];
			cnt_nxt[i] = cnt_r[i];
			if (!en[i])
			begin
				stable_nxt[i] = raw[i];
				cnt_nxt[i] = RST_DBT;
			end
			else if (tick)
			begin
				if (raw[i] == stable_r[i])
					cnt_nxt[i] = RST_DBT;
				else if (cnt_r[i] >= time_r)
				begin
					stable_nxt[i] = raw[i];
					cnt_nxt[i] = RST_DBT;
				end
				else
					cnt_nxt[i] = cnt_r[i] + 8'h01;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stable_r <= RST_WORD;
			time_r <= RST_DBT;
			for (int i = 0; i < NPIN; i++)
				cnt_r[i] <= RST_DBT;
		end
		else
		begin
			stable_r <= stable_nxt;
			time_r <= time_nxt;
			for (int i = 0; i < NPIN; i++)
				cnt_r[i] <= cnt_nxt[i];
		end
	end

	assign filt = stable_r;

	chk_filter_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
		!tick && $stable(en) |=> ((filt ^ $past(filt)) & $past(en)) == RST_WORD)
		else $error("filtered pin moved without a slow tick");
endmodule : debounce_cell

/* src/gpio_bank.sv */
/*
 * 32-pin GPIO bank: APB registers, output drive, input capture with
 * debounce, two interrupt generators and an idle wake-up request.
 * Assumes idle request comes from logic on SYS_CLK; pins and the slow
 * debounce clock are asynchronous and are synchronised here.
 */
// Added by the designer: the APB register port and the register offsets.
module gpio_bank
	import gpio_bank_pkg::*;
(
	input  wire logic            SYS_CLK,
	input  wire logic            RSTN,
	input  wire logic            PSEL,
	input  wire logic            PENABLE,
	input  wire logic            PWRITE,
	input  wire logic [AW-1:0]   PADDR,
	input  wire logic [31:0]     PWDATA,
	output logic      [31:0]     PRDATA,
	output logic                 PREADY,
	output logic                 PSLVERR,
	input  wire logic [NPIN-1:0] PAD_IN,
	output logic      [NPIN-1:0] PAD_OUT,
	output logic      [NPIN-1:0] PAD_OE,
	input  wire logic            DBCLK,
	output logic                 IRQ_FIRST,
	output logic                 IRQ_SECOND,
	input  wire logic            IDLE_REQ,
	output logic                 IDLE_ACK,
	output logic                 WAKE_REQ
);
	logic [NPIN-1:0] pin_s1_r, pin_s2_r, din_r, prev_r, filt, up, dn, ev, wk_ev;
	logic            dbc_s1_r, dbc_s2_r, dbc_s3_r, srst_r, srst_nxt, rst_all;
	logic [1:0]      idle_r, idle_nxt;
	logic            dis_r, dis_nxt, done_r, dbt_pend_r, dbt_pend_nxt;
	logic [NPIN-1:0] oe_r, oe_nxt, out_r, out_nxt, ien1_r, ien1_nxt, ien2_r, ien2_nxt;
	logic [NPIN-1:0] wen_r, wen_nxt, st1_r, st1_nxt, st2_r, st2_nxt, dben_r, dben_nxt;
	logic [NPIN-1:0] rise_r, rise_nxt, fall_r, fall_nxt, low_r, low_nxt, high_r, high_nxt;
	logic [DBTW-1:0] dbt_r, dbt_nxt;
	logic [31:0]     prdata_r, prdata_nxt;
	logic            pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic            irq1_r, irq1_nxt, irq2_r, irq2_nxt, wake_r, wake_nxt, ack_r;
	pwr_t            pwr_r, pwr_nxt;
	logic            acc, wr, tick, live, idle_ok;

	// updates a set/clear register from whichever of its three words is hit
	function automatic logic [31:0] sc_write(input logic [31:0] cur,
		input logic [AW-1:0] a, input logic [AW-1:0] base, input logic [31:0] wd);
		if (a == base)
			return wd;
		if (a == base + OFF_CLR_INC)
			return cur & ~wd;
		if (a == base + OFF_SET_INC)
			return cur | wd;
		return cur;
	endfunction : sc_write

	// pins and slow clock are foreign: two flops before any use
	always_ff @(posedge SYS_CLK)
	begin
		if (!RSTN)
		begin
			pin_s1_r <= RST_WORD;
			pin_s2_r <= RST_WORD;
			dbc_s1_r <= 1'b0;
			dbc_s2_r <= 1'b0;
			dbc_s3_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= PAD_IN;
			pin_s2_r <= pin_s1_r;
			dbc_s1_r <= DBCLK;
			dbc_s2_r <= dbc_s1_r;
			dbc_s3_r <= dbc_s2_r;
		end
	end

	// disable gates the slow clock path but not the bus
	assign tick = dbc_s2_r & ~dbc_s3_r & ~dis_r;
	assign rst_all = !RSTN || srst_r;

	debounce_cell u_debounce (
		.clk   (SYS_CLK),
		.rst_n (!rst_all),
		.tick  (tick),
		.raw   (pin_s2_r),
		.en    (dben_r),
		.dtime (dbt_r),
		.filt  (filt)
	);

	assign acc = PSEL && PENABLE;
	assign wr = acc && pready_r && PWRITE;
	assign up = filt & ~prev_r;
	assign dn = ~filt & prev_r;
	assign ev = (up & rise_r) | (dn & fall_r) | (~filt & low_r) | (filt & high_r);
	assign wk_ev = ((up & rise_r) | (dn & fall_r)) & wen_r;
	assign live = !dis_r && (pwr_r == PWR_ACTIVE);

	always_comb
	begin
		srst_nxt = wr && (PADDR == OFF_SYS) && PWDATA[SYS_SRST_BIT];
		idle_nxt = idle_r;
		dis_nxt = dis_r;
		oe_nxt = oe_r;
		rise_nxt = rise_r;
		fall_nxt = fall_r;
		low_nxt = low_r;
		high_nxt = high_r;
		dben_nxt = dben_r;
		dbt_nxt = dbt_r;
		dbt_pend_nxt = dbt_pend_r && !tick;
		out_nxt = out_r;
		ien1_nxt = ien1_r;
		ien2_nxt = ien2_r;
		wen_nxt = wen_r;
		st1_nxt = st1_r;
		st2_nxt = st2_r;
		if (wr)
		begin
			out_nxt = sc_write(out_r, PADDR, OFF_OUT, PWDATA);
			ien1_nxt = sc_write(ien1_r, PADDR, OFF_IEN1, PWDATA);
			ien2_nxt = sc_write(ien2_r, PADDR, OFF_IEN2, PWDATA);
			wen_nxt = sc_write(wen_r, PADDR, OFF_WEN, PWDATA);
			unique case (PADDR)
				OFF_SYS:  idle_nxt = PWDATA[SYS_IDLE_LSB +: 2];
				OFF_CTRL: dis_nxt = PWDATA[CTRL_DIS_BIT];
				OFF_OE:   oe_nxt = PWDATA;
				OFF_ST1:  st1_nxt = st1_r & ~PWDATA;
				OFF_ST2:  st2_nxt = st2_r & ~PWDATA;
				OFF_RISE: rise_nxt = PWDATA;
				OFF_FALL: fall_nxt = PWDATA;
				OFF_LOW:  low_nxt = PWDATA;
				OFF_HIGH: high_nxt = PWDATA;
				OFF_DBEN: dben_nxt = PWDATA;
				OFF_DBT:
				begin
					dbt_nxt = PWDATA[DBTW-1:0];
					dbt_pend_nxt = 1'b1;
				end
				default: ;
			endcase
		end
		// a new event outranks a clear written in the same cycle
		if (live)
		begin
			st1_nxt = st1_nxt | (ev & ien1_r);
			st2_nxt = st2_nxt | (ev & ien2_r);
		end
		irq1_nxt = |st1_nxt;
		irq2_nxt = |st2_nxt;
	end

	// answer one cycle into the access phase, with data already latched
	always_comb
	begin
		pready_nxt = acc && !pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (acc && !pready_r)
		begin
			pslverr_nxt = !((PADDR[1:0] == 2'h0) && (PADDR <= OFF_STAT));
			unique case (PADDR)
				OFF_SYS:  prdata_nxt = {27'h0, idle_r, 1'b0, srst_r, 1'b0};
				OFF_CTRL: prdata_nxt = {31'h0, dis_r};
				OFF_OE:   prdata_nxt = oe_r;
				OFF_DIN:  prdata_nxt = din_r;
				OFF_ST1:  prdata_nxt = st1_r;
				OFF_ST2:  prdata_nxt = st2_r;
				OFF_RISE: prdata_nxt = rise_r;
				OFF_FALL: prdata_nxt = fall_r;
				OFF_LOW:  prdata_nxt = low_r;
				OFF_HIGH: prdata_nxt = high_r;
				OFF_DBEN: prdata_nxt = dben_r;
				OFF_DBT:  prdata_nxt = {24'h0, dbt_r};
				OFF_STAT: prdata_nxt = {31'h0, done_r};
				OFF_OUT, OFF_OUT + OFF_CLR_INC, OFF_OUT + OFF_SET_INC:    prdata_nxt = out_r;
				OFF_IEN1, OFF_IEN1 + OFF_CLR_INC, OFF_IEN1 + OFF_SET_INC: prdata_nxt = ien1_r;
				OFF_IEN2, OFF_IEN2 + OFF_CLR_INC, OFF_IEN2 + OFF_SET_INC: prdata_nxt = ien2_r;
				OFF_WEN, OFF_WEN + OFF_CLR_INC, OFF_WEN + OFF_SET_INC:    prdata_nxt = wen_r;
				default:  prdata_nxt = RST_WORD;
			endcase
		end
	end

	always_comb
	begin
		unique case (idle_t'(idle_r))
			IDLE_FORCE: idle_ok = 1'b1;
			IDLE_NONE:  idle_ok = 1'b0;
			IDLE_SMART, IDLE_SMRT2:
				idle_ok = (st1_r == RST_WORD) && (st2_r == RST_WORD) && !dbt_pend_r;
		endcase
		pwr_nxt = pwr_r;
		unique case (pwr_r)
			PWR_ACTIVE: if (IDLE_REQ && idle_ok) pwr_nxt = PWR_IDLE;
			PWR_IDLE:   if (!IDLE_REQ) pwr_nxt = PWR_ACTIVE;
		endcase
		// wake stays up until the idle request is withdrawn or the bank is disabled
		wake_nxt = (pwr_r == PWR_IDLE) && !dis_r && (wake_r || (|wk_ev));
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RSTN)
			srst_r <= 1'b0;
		else
			srst_r <= srst_nxt;
	end

	// pad drivers only; pulls and open drain live in the pad ring
	always_ff @(posedge SYS_CLK)
	begin
		if (rst_all)
		begin
			idle_r <= RST_IDLE;
			dis_r <= 1'b0;
			done_r <= 1'b0;
			oe_r <= RST_WORD;
			out_r <= RST_WORD;
			ien1_r <= RST_WORD;
			ien2_r <= RST_WORD;
			wen_r <= RST_WORD;
			st1_r <= RST_WORD;
			st2_r <= RST_WORD;
			rise_r <= RST_WORD;
			fall_r <= RST_WORD;
			low_r <= RST_WORD;
			high_r <= RST_WORD;
			dben_r <= RST_WORD;
			din_r <= RST_WORD;
			prev_r <= RST_WORD;
			dbt_r <= RST_DBT;
			dbt_pend_r <= 1'b0;
			prdata_r <= RST_WORD;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq1_r <= 1'b0;
			irq2_r <= 1'b0;
			wake_r <= 1'b0;
			ack_r <= 1'b0;
			pwr_r <= PWR_ACTIVE;
		end
		else
		begin
			idle_r <= idle_nxt;
			dis_r <= dis_nxt;
			done_r <= 1'b1;
			oe_r <= oe_nxt;
			out_r <= out_nxt;
			ien1_r <= ien1_nxt;
			ien2_r <= ien2_nxt;
			wen_r <= wen_nxt;
			st1_r <= st1_nxt;
			st2_r <= st2_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			low_r <= low_nxt;
			high_r <= high_nxt;
			dben_r <= dben_nxt;
			din_r <= filt;
			prev_r <= filt;
			dbt_r <= dbt_nxt;
			dbt_pend_r <= dbt_pend_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq1_r <= irq1_nxt;
			irq2_r <= irq2_nxt;
			wake_r <= wake_nxt;
			ack_r <= (pwr_nxt == PWR_IDLE);
			pwr_r <= pwr_nxt;
		end
	end

	assign PAD_OE = oe_r;
	assign PAD_OUT = out_r;
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign IRQ_FIRST = irq1_r;
	assign IRQ_SECOND = irq2_r;
	assign WAKE_REQ = wake_r;
	assign IDLE_ACK = ack_r;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	chk_oe_write: assert property (wr && PADDR == OFF_OE && !srst_r |=> PAD_OE == $past(PWDATA))
		else $error("output enable did not take the written word");
	chk_out_set: assert property (wr && PADDR == OFF_OUT + OFF_SET_INC && !srst_r
		|=> PAD_OUT == ($past(PAD_OUT) | $past(PWDATA)))
		else $error("set alias did not OR into output value");
	chk_ien_clr: assert property (wr && PADDR == OFF_IEN1 + OFF_CLR_INC && !srst_r
		|=> ien1_r == ($past(ien1_r) & ~$past(PWDATA)))
		else $error("clear alias did not clear enable bits");
	chk_irq_raise: assert property (live && (ev & ien2_r) != RST_WORD && !srst_r
		|=> IRQ_SECOND && st2_r != RST_WORD)
		else $error("enabled event did not raise second interrupt");
	chk_key_low: assert property (live && (~filt & low_r & ien1_r) != RST_WORD && !srst_r
		|=> IRQ_FIRST ##1 IRQ_FIRST)
		else $error("low row level did not hold first interrupt");
	chk_disable_quiet: assert property (dis_r && st1_r == RST_WORD |=> st1_r == RST_WORD)
		else $error("disabled bank set interrupt status");
	chk_wake_idle: assert property ($rose(WAKE_REQ) |-> $past(pwr_r) == PWR_IDLE)
		else $error("wake raised outside idle");
	chk_srst_done: assert property (srst_r |=> !srst_r && PAD_OE == RST_WORD && !PREADY)
		else $error("software reset did not clear the bank");
	chk_smart_ack: assert property ($rose(IDLE_ACK) && idle_r[1]
		|-> $past(st1_r == RST_WORD && st2_r == RST_WORD && !dbt_pend_r))
		else $error("smart idle acked with activity pending");
	chk_apb_wait: assert property (acc && !pready_r |=> PREADY ##1 !PREADY)
		else $error("apb answer not exactly one wait cycle");

	cov_irq_first: cover property (live ##1 $rose(IRQ_FIRST));
	cov_wake: cover property (IDLE_ACK ##1 $rose(WAKE_REQ));
	cov_set_clr: cover property (wr && PADDR == OFF_WEN + OFF_SET_INC);
	cov_srst: cover property ($rose(srst_r));
endmodule : gpio_bank

/* src/gpio_bank_pkg.sv */
/*
 * Shared constants for the 32-pin bank: register byte offsets, reset values,
 * idle behaviour codes and power states.
 * Assumes APB with 32-bit data and an 8-bit byte address.
 */
package gpio_bank_pkg;
	localparam int NPIN = 32;
	localparam int AW   = 8;
	localparam int DBTW = 8;

	localparam logic [AW-1:0] OFF_SYS     = 8'h00;
	localparam logic [AW-1:0] OFF_CTRL    = 8'h04;
	localparam logic [AW-1:0] OFF_OE      = 8'h08;
	localparam logic [AW-1:0] OFF_DIN     = 8'h0C;
	localparam logic [AW-1:0] OFF_OUT     = 8'h10;
	localparam logic [AW-1:0] OFF_IEN1    = 8'h1C;
	localparam logic [AW-1:0] OFF_IEN2    = 8'h28;
	localparam logic [AW-1:0] OFF_WEN     = 8'h34;
	localparam logic [AW-1:0] OFF_ST1     = 8'h40;
	localparam logic [AW-1:0] OFF_ST2     = 8'h44;
	localparam logic [AW-1:0] OFF_RISE    = 8'h48;
	localparam logic [AW-1:0] OFF_FALL    = 8'h4C;
	localparam logic [AW-1:0] OFF_LOW     = 8'h50;
	localparam logic [AW-1:0] OFF_HIGH    = 8'h54;
	localparam logic [AW-1:0] OFF_DBEN    = 8'h58;
	localparam logic [AW-1:0] OFF_DBT     = 8'h5C;
	localparam logic [AW-1:0] OFF_STAT    = 8'h60;
	// set-and-clear aliases sit at base + 4 (clear) and base + 8 (set)
	localparam logic [AW-1:0] OFF_CLR_INC = 8'h04;
	localparam logic [AW-1:0] OFF_SET_INC = 8'h08;

	localparam int SYS_SRST_BIT = 1;
	localparam int SYS_IDLE_LSB = 3;
	localparam int CTRL_DIS_BIT = 0;

	localparam logic [31:0]     RST_WORD = 32'h0000_0000;
	localparam logic [DBTW-1:0] RST_DBT  = 8'h00;
	localparam logic [1:0]      RST_IDLE = 2'h2;

	typedef enum logic [1:0] {
		IDLE_FORCE = 2'b00,
		IDLE_NONE  = 2'b01,
		IDLE_SMART = 2'b10,
		IDLE_SMRT2 = 2'b11
	} idle_t;

	typedef enum logic {
		PWR_ACTIVE = 1'b0,
		PWR_IDLE   = 1'b1
	} pwr_t;
endpackage : gpio_bank_pkg
